// ### rtl/sscp_device.sv
// Sensor end of the serial command port
// What the document requires of both ends of the link
// (RULE_01) Mode 3: sample input on rising clock
// (RULE_02) Host opens frame: select low, clock high
// (RULE_03) Host bit rate at most 5 Mbps
// (RULE_04) Operation code answered by acknowledge byte
// (RULE_05) 0x72 resets to shutdown, 0x94 idles
// (RULE_06) 0xA0..0xA6 start measurement, settings 1-4
// (RULE_07) Result code: acknowledge, 24-bit word MSB first
// (RULE_08) 0xC0 raw, 0xC4/0xC6 smoothed pressure
// (RULE_09) 0xC2 uses same result format
// (RULE_10) Status 0x80 uses same result format
// (RULE_11) Store read 0xD6, acknowledge, address byte
// (RULE_12) Busy up to 25 us, sends 00h
// (RULE_13) Then 01h followed by stored byte
// (RULE_14) Host keeps clocking until 01h seen
// (RULE_15) Release data line within 170 ns
// (RULE_16) 0xC2 returns temperature
// (RULE_17) Result words are two's complement
// (RULE_18) Data changes on falling clock edges
// (RULE_19) Unknown codes ignored until select rises
`timescale 1ns/1ps
`default_nettype none
module sscp_device #(
   parameter logic [7:0] NV_BYTE_A = 8'h5A, // Arbitrary identity byte
   parameter logic [7:0] NV_BYTE_B = 8'h3C  // Arbitrary identity byte
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   sscp_if.device link,
   input wire logic [23:0] pressure_raw_i,
   input wire logic [23:0] pressure_smooth1_i,
   input wire logic [23:0] pressure_smooth2_i,
   input wire logic [23:0] temperature_i,
   input wire logic [23:0] status_i,
   output logic sensor_reset_o,
   output logic idle_o,
   output logic measure_start_o,
   output logic [1:0] measure_setting_o
);
   import sscp_pkg::*;
   // ***************************************
   // Declarations
   // ***************************************
   typedef enum logic [2:0] {
      ST_CMD, ST_ACK, ST_WORD, ST_ADDR, ST_BUSY, ST_NVDATA, ST_IGNORE
   } sscp_dst_e;
   logic [2:0] s1_r, s2_r; // Pin synchronisers: sclk, select, mosi
   logic sclk_d_r; // Previous synced clock
   logic sclk_s, cs_s, mosi_s; // Synced pins
   logic rise, fall; // Link clock edges
   sscp_dst_e st_r, st_nxt; // Frame phase
   logic [2:0] cnt_r, cnt_nxt; // Bit in byte
   logic [7:0] rx_r, rx_nxt; // Incoming byte
   logic [7:0] code_r, code_nxt; // Code of this frame, kept past the shift register
   logic [7:0] tx_r, tx_nxt; // Outgoing byte
   logic miso_r, miso_nxt; // Data pin level
   logic oe_r, oe_nxt; // Data pin enable
   logic [23:0] word_r, word_nxt; // Latched result
   logic [1:0] widx_r, widx_nxt; // Result bytes left
   logic [7:0] nv_r, nv_nxt; // Fetched store byte
   logic [11:0] busy_r, busy_nxt; // Preparation countdown
   logic rst_nxt, idle_nxt, meas_nxt; // Action pulses
   logic [1:0] set_nxt; // Measurement setting
   logic [7:0] byte_v; // Byte completed this edge
   // ***************************************
   // Pin synchronisers
   // ***************************************
   // First stage feeds only the second
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_r <= 3'h3;
         s2_r <= 3'h3;
         sclk_d_r <= 1'b1;
      end else begin
         s1_r <= {link.mosi, link.chip_select_low, link.sclk};
         s2_r <= s1_r;
         sclk_d_r <= s2_r[0];
      end
   end
   assign sclk_s = s2_r[0];
   assign cs_s = s2_r[1];
   assign mosi_s = s2_r[2];
   assign rise = sclk_s && !sclk_d_r; // see RULE_01
   assign fall = !sclk_s && sclk_d_r; // see RULE_18
   // ***************************************
   // Frame sequencer
   // ***************************************
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      rx_nxt = rx_r;
      code_nxt = code_r;
      tx_nxt = tx_r;
      miso_nxt = miso_r;
      oe_nxt = oe_r;
      word_nxt = word_r;
      widx_nxt = widx_r;
      nv_nxt = nv_r;
      busy_nxt = (busy_r != 12'h000) ? busy_r - 12'h001 : busy_r;
      rst_nxt = 1'b0;
      idle_nxt = 1'b0;
      meas_nxt = 1'b0;
      set_nxt = measure_setting_o;
      byte_v = {rx_r[6:0], mosi_s};
      if (cs_s) begin
         // Deselected: release the line, rearm for the next frame
         st_nxt = ST_CMD; // see RULE_19
         cnt_nxt = 3'h0;
         tx_nxt = FILL_BYTE;
         miso_nxt = 1'b0;
         oe_nxt = 1'b0; // see RULE_15
      end else begin
         oe_nxt = 1'b1;
         // Shift on falling edge so the host sees a settled bit
         if (fall) begin
            miso_nxt = tx_r[7]; // see RULE_18
            tx_nxt = {tx_r[6:0], 1'b0};
         end
         if (rise) begin
            rx_nxt = byte_v; // see RULE_01
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
               tx_nxt = FILL_BYTE;
               unique case (st_r)
                  ST_CMD: begin
                     // The shift register is overwritten during the ack byte
                     code_nxt = byte_v;
                     unique case (sscp_kind(byte_v))
                        K_OP: begin
                           tx_nxt = ACK_BYTE; // see RULE_04
                           st_nxt = ST_ACK;
                           // Actions take effect as the code lands
                           rst_nxt = (byte_v == CMD_RESET); // see RULE_05
                           idle_nxt = (byte_v == CMD_IDLE); // see RULE_05
                           if (byte_v[7:4] == CMD_MEAS1[7:4]) begin
                              meas_nxt = 1'b1; // see RULE_06
                              set_nxt = byte_v[2:1]; // see RULE_06
                           end
                        end
                        K_WORD: begin
                           tx_nxt = ACK_BYTE; // see RULE_07
                           st_nxt = ST_ACK;
                           // Words pass through signed untouched
                           unique case (byte_v)
                              CMD_RAW: word_nxt = pressure_raw_i; // see RULE_08
                              CMD_SMOOTH1: word_nxt = pressure_smooth1_i; // see RULE_08
                              CMD_SMOOTH2: word_nxt = pressure_smooth2_i; // see RULE_08
                              CMD_TEMP: word_nxt = temperature_i; // see RULE_09 RULE_16
                              default: word_nxt = status_i; // see RULE_10 RULE_17
                           endcase
                        end
                        K_NV: begin
                           tx_nxt = ACK_BYTE; // see RULE_11
                           st_nxt = ST_ACK;
                        end
                        default: st_nxt = ST_IGNORE; // see RULE_19
                     endcase
                  end
                  ST_ACK: begin
                     // Acknowledge has gone out, pick the follow-up
                     if (sscp_kind(code_r) == K_WORD) begin
                        tx_nxt = word_r[23:16]; // see RULE_07
                        widx_nxt = 2'h2;
                        st_nxt = ST_WORD;
                     end else if (sscp_kind(code_r) == K_NV) begin
                        st_nxt = ST_ADDR; // see RULE_11
                     end else begin
                        st_nxt = ST_IGNORE;
                     end
                  end
                  ST_WORD: begin
                     // Most significant byte first
                     tx_nxt = (widx_r == 2'h2) ? word_r[15:8] : word_r[7:0]; // see RULE_07
                     widx_nxt = widx_r - 2'h1;
                     // Low byte has gone out, nothing more to send
                     if (widx_r == 2'h0) begin
                        tx_nxt = FILL_BYTE;
                        st_nxt = ST_IGNORE;
                     end
                  end
                  ST_ADDR: begin
                     // Unknown addresses read back as zero
                     nv_nxt = (byte_v == NV_ADDR_A) ? NV_BYTE_A :
                              (byte_v == NV_ADDR_B) ? NV_BYTE_B : 8'h00; // see RULE_11
                     busy_nxt = NV_PREP_CYC[11:0]; // see RULE_12
                     tx_nxt = BUSY_BYTE; // see RULE_12
                     st_nxt = ST_BUSY;
                  end
                  ST_BUSY: begin
                     // At slow link clocks the second poll byte may already be ready; the first is always busy
                     if (busy_r == 12'h000) begin
                        tx_nxt = READY_BYTE; // see RULE_13
                        st_nxt = ST_NVDATA;
                     end else begin
                        tx_nxt = BUSY_BYTE; // see RULE_12
                     end
                  end
                  ST_NVDATA: begin
                     tx_nxt = nv_r; // see RULE_13
                     st_nxt = ST_IGNORE;
                  end
                  ST_IGNORE: tx_nxt = FILL_BYTE; // see RULE_19
               endcase
            end
         end
      end
   end
   // Register the sequencer
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= ST_CMD;
         cnt_r <= 3'h0;
         rx_r <= 8'h00;
         code_r <= 8'h00;
         tx_r <= 8'h00;
         miso_r <= 1'b0;
         oe_r <= 1'b0;
         word_r <= 24'h000000;
         widx_r <= 2'h0;
         nv_r <= 8'h00;
         busy_r <= 12'h000;
         sensor_reset_o <= 1'b0;
         idle_o <= 1'b0;
         measure_start_o <= 1'b0;
         measure_setting_o <= 2'h0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         rx_r <= rx_nxt;
         code_r <= code_nxt;
         tx_r <= tx_nxt;
         miso_r <= miso_nxt;
         oe_r <= oe_nxt;
         word_r <= word_nxt;
         widx_r <= widx_nxt;
         nv_r <= nv_nxt;
         busy_r <= busy_nxt;
         sensor_reset_o <= rst_nxt;
         idle_o <= idle_nxt;
         measure_start_o <= meas_nxt;
         measure_setting_o <= set_nxt;
      end
   end
   assign link.miso = miso_r;
   assign link.miso_oe = oe_r;
endmodule : sscp_device
`default_nettype wire

// ### inc/sscp_pkg.sv
// Shared constants, command codes and decode for the sensor command port
`default_nettype none
package sscp_pkg;
   // ***************************************
   // Timing
   // ***************************************
   localparam int CLK_MHZ = 100; // System clock rate
   localparam int NV_PREP_NS = 2000; // Store preparation time, under the 25 us ceiling
   localparam int NV_PREP_CYC = NV_PREP_NS * CLK_MHZ / 1000;
   localparam int HOST_HALF_NS = 100; // Half link bit, 5 Mbps
   localparam int HOST_HALF_CYC = (HOST_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int CS_HIGH_NS = 200; // Least deselect time between frames
   localparam int CS_HIGH_CYC = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
   // ***************************************
   // Command codes and fixed bytes
   // ***************************************
   localparam logic [7:0] CMD_RESET = 8'h72;
   localparam logic [7:0] CMD_IDLE = 8'h94;
   localparam logic [7:0] CMD_MEAS1 = 8'hA0;
   localparam logic [7:0] CMD_MEAS2 = 8'hA2;
   localparam logic [7:0] CMD_MEAS3 = 8'hA4;
   localparam logic [7:0] CMD_MEAS4 = 8'hA6;
   localparam logic [7:0] CMD_RAW = 8'hC0;
   localparam logic [7:0] CMD_TEMP = 8'hC2;
   localparam logic [7:0] CMD_SMOOTH1 = 8'hC4;
   localparam logic [7:0] CMD_SMOOTH2 = 8'hC6;
   localparam logic [7:0] CMD_STATUS = 8'h80;
   localparam logic [7:0] CMD_NVREAD = 8'hD6;
   localparam logic [7:0] NV_ADDR_A = 8'h75;
   localparam logic [7:0] NV_ADDR_B = 8'h76;
   localparam logic [7:0] BUSY_BYTE = 8'h00;
   localparam logic [7:0] READY_BYTE = 8'h01;
   localparam logic [7:0] ACK_BYTE = 8'hA5;
   localparam logic [7:0] FILL_BYTE = 8'h00;
   localparam int FIFO_DEPTH = 16;
   // Command classes
   typedef enum logic [1:0] {K_NONE, K_OP, K_WORD, K_NV} sscp_kind_e;
   // Classify a received code; both ends use it
   function automatic sscp_kind_e sscp_kind(input logic [7:0] c);
      unique case (c)
         CMD_RESET, CMD_IDLE, CMD_MEAS1, CMD_MEAS2, CMD_MEAS3, CMD_MEAS4: return K_OP;
         CMD_RAW, CMD_TEMP, CMD_SMOOTH1, CMD_SMOOTH2, CMD_STATUS: return K_WORD;
         CMD_NVREAD: return K_NV;
         default: return K_NONE;
      endcase
   endfunction : sscp_kind
endpackage : sscp_pkg
`default_nettype wire

// ### inc/sscp_if.sv
// Serial link between host and sensor command port
`timescale 1ns/1ps
`default_nettype none
interface sscp_if;
   logic sclk; // Serial clock, idles high
   logic chip_select_low; // Frame select, low active
   logic mosi; // Host to device data
   logic miso; // Device data
   logic miso_oe; // Device drives miso
   wire miso_line; // Line level, pulled high when released
   assign miso_line = miso_oe ? miso : 1'b1;
   modport device(input sclk, input chip_select_low, input mosi, output miso, output miso_oe);
   modport host(output sclk, output chip_select_low, output mosi, input miso_line);
endinterface : sscp_if
`default_nettype wire

// ### rtl/sscp_fifo.sv
// Request FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sscp_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D]; // Storage
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt; // Pointers
   logic [AW:0] cnt_r, cnt_nxt; // Fill level
   logic push, pop;
   // ***************************************
   // Pointer and level update
   // ***************************************
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   // Flags are registered so ready never ripples back combinationally
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         in_ready_o <= (cnt_nxt != D[AW:0]);
         out_valid_o <= (cnt_nxt != '0);
      end
   end
   // Storage has no reset
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wp_r] <= in_data_i;
      end
   end
   assign out_data_o = mem[rp_r];
endmodule : sscp_fifo
`default_nettype wire

// ### rtl/sscp_host.sv
// Host end: queues requests and runs frames on the serial link
`timescale 1ns/1ps
`default_nettype none
module sscp_host (
   input wire logic clock_i,
   input wire logic nrst_i,
   sscp_if.host link,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [7:0] req_cmd_i,
   input wire logic [7:0] req_addr_i,
   output logic rsp_valid_o,
   output logic [7:0] rsp_ack_o,
   output logic [23:0] rsp_data_o,
   output logic busy_o
);
   import sscp_pkg::*;
   // ***************************************
   // Declarations
   // ***************************************
   typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_LAG, H_GAP} sscp_hst_e;
   sscp_hst_e st_r, st_nxt; // Frame phase
   logic q_valid, q_pop; // Queue drain side
   logic [15:0] q_data; // {addr, cmd}
   logic [1:0] ms_r; // Data line synchroniser
   logic [4:0] tm_r, tm_nxt; // Phase timer
   logic [2:0] bit_r, bit_nxt; // Bit in byte
   logic [3:0] bx_r, bx_nxt; // Byte index, saturating
   logic [7:0] cmd_r, cmd_nxt, addr_r, addr_nxt, tx_r, tx_nxt, rx_r, rx_nxt;
   logic rdy_r, rdy_nxt; // Ready byte seen
   logic sclk_r, sclk_nxt, cs_r, cs_nxt, mosi_r, mosi_nxt;
   logic rv_nxt, busy_nxt; // Output next values
   logic [7:0] ack_nxt;
   logic [23:0] dat_nxt;
   logic done; // Frame complete at this byte
   sscp_fifo #(.W(16), .D(FIFO_DEPTH)) u_q (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .in_valid_i(req_valid_i),
      .in_ready_o(req_ready_o),
      .in_data_i({req_addr_i, req_cmd_i}),
      .out_valid_o(q_valid),
      .out_ready_i(q_pop),
      .out_data_o(q_data)
   );
   // ***************************************
   // Frame engine, clock divided from clock_i
   // ***************************************
   always_comb begin
      st_nxt = st_r;
      tm_nxt = (tm_r != 5'h00) ? tm_r - 5'h01 : tm_r;
      bit_nxt = bit_r;
      bx_nxt = bx_r;
      cmd_nxt = cmd_r;
      addr_nxt = addr_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      rdy_nxt = rdy_r;
      sclk_nxt = sclk_r;
      cs_nxt = cs_r;
      mosi_nxt = mosi_r;
      rv_nxt = 1'b0;
      busy_nxt = (st_r != H_IDLE);
      ack_nxt = rsp_ack_o;
      dat_nxt = rsp_data_o;
      q_pop = 1'b0;
      done = 1'b0;
      unique case (st_r)
         H_IDLE: if (q_valid) begin
            // Select falls while the clock idles high
            q_pop = 1'b1;
            cmd_nxt = q_data[7:0];
            addr_nxt = q_data[15:8];
            tx_nxt = q_data[7:0];
            cs_nxt = 1'b0; // see RULE_02
            bx_nxt = 4'h0;
            rdy_nxt = 1'b0;
            tm_nxt = HOST_HALF_CYC[4:0];
            st_nxt = H_LEAD;
            busy_nxt = 1'b1;
         end
         H_LEAD: if (tm_r == 5'h00) begin
            sclk_nxt = 1'b0;
            mosi_nxt = tx_r[7];
            tm_nxt = HOST_HALF_CYC[4:0];
            st_nxt = H_LOW;
         end
         H_LOW: if (tm_r == 5'h00) begin
            // Half-bit timing of 11 clocks keeps the rate near 4.5 Mbps
            sclk_nxt = 1'b1; // see RULE_03
            rx_nxt = {rx_r[6:0], ms_r[1]};
            bit_nxt = bit_r + 3'h1;
            tm_nxt = HOST_HALF_CYC[4:0];
            st_nxt = H_HIGH;
         end
         H_HIGH: if (tm_r == 5'h00) begin
            if (bit_r != 3'h0) begin
               sclk_nxt = 1'b0;
               tx_nxt = {tx_r[6:0], 1'b0};
               mosi_nxt = tx_r[6];
               tm_nxt = HOST_HALF_CYC[4:0];
               st_nxt = H_LOW;
            end else begin
               tx_nxt = FILL_BYTE;
               bx_nxt = (bx_r != 4'hF) ? bx_r + 4'h1 : bx_r;
               if (bx_r == 4'h1) begin
                  ack_nxt = rx_r;
                  done = (sscp_kind(cmd_r) == K_OP) || (sscp_kind(cmd_r) == K_NONE);
                  if (sscp_kind(cmd_r) == K_NV) begin
                     tx_nxt = addr_r; // see RULE_11
                  end
               end else if (bx_r != 4'h0) begin
                  if (sscp_kind(cmd_r) == K_WORD) begin
                     dat_nxt = {rsp_data_o[15:0], rx_r};
                     done = (bx_r == 4'h4);
                  end else if (bx_r != 4'h2) begin
                     // Keep polling until the ready byte shows
                     if (rdy_r) begin
                        dat_nxt = {16'h0000, rx_r}; // see RULE_14
                        done = 1'b1;
                     end else begin
                        rdy_nxt = (rx_r == READY_BYTE); // see RULE_14
                     end
                  end
               end
               tm_nxt = HOST_HALF_CYC[4:0];
               if (done) begin
                  st_nxt = H_LAG;
               end else begin
                  sclk_nxt = 1'b0;
                  mosi_nxt = tx_nxt[7];
                  st_nxt = H_LOW;
               end
            end
         end
         H_LAG: if (tm_r == 5'h00) begin
            cs_nxt = 1'b1;
            rv_nxt = 1'b1;
            tm_nxt = CS_HIGH_CYC[4:0];
            st_nxt = H_GAP;
         end
         H_GAP: if (tm_r == 5'h00) begin
            st_nxt = H_IDLE;
         end
      endcase
   end
   // Register engine; ms_r[0] feeds only ms_r[1]
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= H_IDLE;
         ms_r <= 2'h3;
         tm_r <= 5'h00;
         bit_r <= 3'h0;
         bx_r <= 4'h0;
         cmd_r <= 8'h00;
         addr_r <= 8'h00;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         rdy_r <= 1'b0;
         sclk_r <= 1'b1;
         cs_r <= 1'b1;
         mosi_r <= 1'b1;
         rsp_valid_o <= 1'b0;
         rsp_ack_o <= 8'h00;
         rsp_data_o <= 24'h000000;
         busy_o <= 1'b0;
      end else begin
         st_r <= st_nxt;
         ms_r <= {ms_r[0], link.miso_line};
         tm_r <= tm_nxt;
         bit_r <= bit_nxt;
         bx_r <= bx_nxt;
         cmd_r <= cmd_nxt;
         addr_r <= addr_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         rdy_r <= rdy_nxt;
         sclk_r <= sclk_nxt;
         cs_r <= cs_nxt;
         mosi_r <= mosi_nxt;
         rsp_valid_o <= rv_nxt;
         rsp_ack_o <= ack_nxt;
         rsp_data_o <= dat_nxt;
         busy_o <= busy_nxt;
      end
   end
   assign link.sclk = sclk_r;
   assign link.chip_select_low = cs_r;
   assign link.mosi = mosi_r;
endmodule : sscp_host
`default_nettype wire

// ### tb/sscp_sva.sv
// Link checker for the host and sensor ends
`timescale 1ns/1ps
`default_nettype none
module sscp_sva (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic sclk,
   input wire logic chip_select_low,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_line
);
   // ****
   // Wire timing
   // ****
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   chk_clk_idle: assert property (chip_select_low |-> sclk)
      else $error("link clock low outside a frame");
   chk_low_half: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 (!sclk)[*2])
      else $error("link clock low half too short");
   chk_high_half: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*2])
      else $error("link clock high half too short");
   // Host data may only move while the clock is low
   chk_mosi_edge: assert property ($changed(mosi) && !chip_select_low |-> !sclk)
      else $error("host data moved with clock high");
   chk_miso_edge: assert property ($changed(miso) && miso_oe && $past(miso_oe)
      && !chip_select_low |-> !sclk)
      else $error("device data moved with clock high");
   // Deselect gap of 200 ns, 20 clocks
   chk_cs_gap: assert property ($rose(chip_select_low) |->
      chip_select_low[*8] ##1 chip_select_low[*8] ##1 chip_select_low[*4])
      else $error("select high time too short");
   chk_oe_release: assert property ($rose(chip_select_low) |-> ##[1:17] !miso_oe)
      else $error("data line not released in time");
   chk_oe_frame: assert property ($rose(miso_oe) |-> !chip_select_low)
      else $error("data line driven while deselected");
   chk_line_pull: assert property (!miso_oe |-> miso_line)
      else $error("released line not high");
   cover property ($fell(chip_select_low));
   cover property ($rose(miso_oe));
   cover property ($changed(miso) && miso_oe);
endmodule : sscp_sva
`default_nettype wire

// ### tb/testbench.sv
// Bench joining host and sensor ends with a queue model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sscp_pkg::*;
   // ****
   // Signals and model state
   // ****
   logic clock_i, nrst_i, req_valid_i, req_ready_o, rsp_valid_o, busy_o;
   logic [7:0] req_cmd_i, req_addr_i, rsp_ack_o;
   logic [23:0] rsp_data_o, last_data;
   logic [23:0] sens [5]; // Raw, smooth1, smooth2, temperature, status
   logic sensor_reset_o, idle_o, measure_start_o, refused;
   logic [1:0] measure_setting_o;
   logic [31:0] exp_q[$]; // Expected {ack, word} per frame
   int bad_count, n_checks, n_rst, n_idle, n_meas, e_rst, e_idle, e_meas, e_set, n;
   // Every code once, then extras so the queue overflows
   logic [7:0] codes [16] = '{8'h72, 8'h94, 8'hA0, 8'hA2, 8'hA4, 8'hA6, 8'hC0, 8'hC2,
      8'hC4, 8'hC6, 8'h80, 8'hD6, 8'hD6, 8'hD6, 8'h55, 8'hFF};
   sscp_if u_sscp_if ();
   sscp_device #(.NV_BYTE_A(8'h5A), .NV_BYTE_B(8'h3C)) u_sscp_device (.clock_i(clock_i),
      .nrst_i(nrst_i), .link(u_sscp_if.device), .pressure_raw_i(sens[0]),
      .pressure_smooth1_i(sens[1]), .pressure_smooth2_i(sens[2]), .temperature_i(sens[3]),
      .status_i(sens[4]), .sensor_reset_o(sensor_reset_o), .idle_o(idle_o),
      .measure_start_o(measure_start_o), .measure_setting_o(measure_setting_o));
   sscp_host u_sscp_host (.clock_i(clock_i), .nrst_i(nrst_i), .link(u_sscp_if.host),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i),
      .req_addr_i(req_addr_i), .rsp_valid_o(rsp_valid_o), .rsp_ack_o(rsp_ack_o),
      .rsp_data_o(rsp_data_o), .busy_o(busy_o));
   sscp_sva u_sscp_sva (.clock_i(clock_i), .nrst_i(nrst_i), .sclk(u_sscp_if.sclk),
      .chip_select_low(u_sscp_if.chip_select_low), .mosi(u_sscp_if.mosi),
      .miso(u_sscp_if.miso), .miso_oe(u_sscp_if.miso_oe), .miso_line(u_sscp_if.miso_line));
   // ****
   // Tasks
   // ****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   // Offer one request and predict its frame
   task automatic push(input logic [7:0] c, input logic [7:0] a);
      logic [7:0] ack;
      ack = ACK_BYTE;
      case (c)
         8'h72: e_rst++;
         8'h94: e_idle++;
         8'hA0, 8'hA2, 8'hA4, 8'hA6: begin
            e_meas++;
            e_set = (c - 8'hA0) / 2;
         end
         8'hC0: last_data = sens[0];
         8'hC4: last_data = sens[1];
         8'hC6: last_data = sens[2];
         8'hC2: last_data = sens[3];
         8'h80: last_data = sens[4];
         8'hD6: last_data = {16'h0, a == 8'h75 ? 8'h5A : a == 8'h76 ? 8'h3C : 8'h0};
         default: ack = 8'h00; // Unknown code gets fill, word kept
      endcase
      exp_q.push_back({ack, last_data});
      req_cmd_i = c;
      req_addr_i = a;
      req_valid_i = 1'b1;
   endtask : push
   // ****
   // Clock and response monitor
   // ****
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   always @(negedge clock_i) begin
      if (rsp_valid_o === 1'b1)
         check({rsp_ack_o, rsp_data_o}, exp_q.pop_front());
      n_rst += int'(sensor_reset_o === 1'b1);
      n_idle += int'(idle_o === 1'b1);
      n_meas += int'(measure_start_o === 1'b1);
   end
   // ****
   // Main sequence
   // ****
   initial begin
      nrst_i = 1'b0;
      req_valid_i = 1'b0;
      req_cmd_i = 8'h00;
      req_addr_i = 8'h00;
      last_data = 24'h0;
      refused = 1'b0;
      foreach (sens[k]) sens[k] = 24'h0;
      void'($urandom(32'h0DBA));
      repeat (16) @(negedge clock_i);
      nrst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      for (int t = 0; t < 2; t++) begin
         foreach (sens[k]) sens[k] = 24'($urandom());
         sens[0] = (t == 1) ? 24'h800000 : sens[0]; // Signed extremes
         sens[3] = (t == 1) ? 24'h7FFFFF : sens[3];
         n = 0;
         // Back to back offers while ready, one test overflows the queue
         for (int c = 0; c < 20000 && n < 20 - 8 * t; c++) begin
            @(negedge clock_i);
            if (req_ready_o === 1'b1) begin
               push(t == 0 ? codes[n % 16] : codes[$urandom_range(15)], 8'h6A + 8'(n));
               n++;
            end else begin
               req_valid_i = 1'b0;
               refused = 1'b1;
            end
         end
         @(negedge clock_i);
         req_valid_i = 1'b0;
         check(32'(n), 32'(20 - 8 * t));
         for (int c = 0; c < 24000 && (exp_q.size() > 0 || busy_o !== 1'b0); c++)
            @(negedge clock_i);
         // A hang counts once and goes straight to the verdict
         if (exp_q.size() != 0 || busy_o !== 1'b0) begin
            bad_count++;
            break;
         end
         check(32'(refused), 32'h1);
         check(32'(n_rst), 32'(e_rst));
         check(32'(n_idle), 32'(e_idle));
         check(32'(n_meas), 32'(e_meas));
         check(32'(measure_setting_o), 32'(e_set));
         $display("Test %0d done", t);
      end
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
